// ### sim/cbm_chk.sv
// Port assertions for the circuit blocking manager
module cbm_chk import cbm_pkg::*; (
  input wire logic        i_clk, i_rst_b, i_rd_en, i_rx_valid, i_rx_test, o_tx_valid,
  input wire logic        o_setup_accept, o_setup_discard,
  input wire logic [31:0] o_rd_data, i_rx_status, o_tx_status, o_retry, o_release,
  input wire logic [4:0]  i_rx_cic,
  input wire logic [7:0]  i_rx_range,
  input wire cbm_msg_type i_rx_type, o_tx_type
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Message on an allocated label with a legal range
  wire logic ok = i_rx_valid && i_rx_cic != 5'h00 && i_rx_range <= RANGE_MAX;
  a_blk_acked: assert property (ok && i_rx_type == MSG_BLOCK
    |=> o_tx_valid && o_tx_type == MSG_BLOCK_ACK) else $error("no block ack");
  a_unblk_acked: assert property (ok && i_rx_type == MSG_UNBLOCK
    |=> o_tx_valid && o_tx_type == MSG_UNBLOCK_ACK) else $error("no unblock ack");
  a_hw_acked: assert property (ok && i_rx_type == MSG_HGRP_UNBLOCK
    |=> o_tx_valid && o_tx_type == MSG_HGRP_UNBLOCK_ACK) else $error("no hw ack");
  a_ack_subset: assert property (ok && i_rx_type >= MSG_MGRP_BLOCK
    && i_rx_type <= MSG_HGRP_UNBLOCK_ACK
    |=> (o_tx_status & ~$past(i_rx_status)) == 32'h0000_0000) else $error("ack bit added");
  a_range_drop: assert property (i_rx_valid && i_rx_range > RANGE_MAX |=> !o_tx_valid)
    else $error("oversize answered");
  a_read_quiet: assert property (!i_rd_en |=> o_rd_data == 32'h0000_0000)
    else $error("read data outside slot");
  a_setup_one: assert property (ok && i_rx_type == MSG_SETUP && !i_rx_test
    |=> o_setup_accept != o_setup_discard) else $error("setup unanswered");
  a_retry_pair: assert property (o_retry != 32'h0000_0000
    |-> o_release == o_retry && $past(o_tx_valid)) else $error("retry without release");
  c_retry: cover property (o_retry != 32'h0000_0000);
  c_discard: cover property (o_setup_discard);
  c_grp_req: cover property (o_tx_valid && o_tx_type == MSG_MGRP_BLOCK);
endmodule : cbm_chk
bind cbm_top cbm_chk u_chk (.i_clk, .i_rst_b, .i_rd_en, .i_rx_valid, .i_rx_test, .o_tx_valid,
  .o_setup_accept, .o_setup_discard, .o_rd_data, .i_rx_status, .o_tx_status, .o_retry,
  .o_release, .i_rx_cic, .i_rx_range, .i_rx_type, .o_tx_type);

// ### sim/cbm_peer.sv
// Far exchange model: answers each request one cycle after seeing it
module cbm_peer import cbm_pkg::*; (
  input  wire logic        i_clk, i_rst_b, i_tx_valid,
  input  wire cbm_msg_type i_tx_type,
  input  wire logic [4:0]  i_tx_cic,
  input  wire logic [7:0]  i_tx_range,
  input  wire logic [31:0] i_tx_status, i_drop,
  output logic             o_valid,
  output cbm_msg_type      o_type,
  output logic [4:0]       o_cic,
  output logic [7:0]       o_range,
  output logic [31:0]      o_status
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic req = i_tx_valid && i_tx_type inside {1, 2, 5, 6, 9, 10};
  // Acknowledge with label and range echoed; idle fields toggle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_valid <= 1'b0;
    else o_valid <= req;
  end
  always_ff @(posedge i_clk) begin
    o_type <= req ? cbm_msg_type'(i_tx_type + 4'h2) : cbm_msg_type'(~o_type);
    o_cic <= req ? i_tx_cic : ~o_cic;
    o_range <= req ? i_tx_range : ~o_range;
    o_status <= req ? i_tx_status & ~i_drop : ~o_status;
  end
endmodule : cbm_peer

// ### sim/tb.sv
// Self-checking bench for the circuit blocking manager
module tb;
  import cbm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, wr_en, rd_en, bv, btst, pv, tx_valid, call_valid, acc, dis, note, bsy;
  logic [7:0] addr, br, pr, tx_range;
  logic [4:0] bc, pc, tx_cic, call_cic, c;
  logic [31:0] wdata, bs, ps, drop, rd_data, tx_status, retry, rel, seed, rem_exp, d, hwr;
  cbm_msg_type bt, pt, tx_type, t;
  cbm_op_type call_op;
  int miscompares, check_count, cyc, i;
  cbm_top uut (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .o_rd_data(rd_data), .i_rx_valid(bv | pv), .i_rx_type(bv ? bt : pt),
    .i_rx_cic(bv ? bc : pc), .i_rx_range(bv ? br : pr), .i_rx_status(bv ? bs : ps),
    .i_rx_test(btst), .o_tx_valid(tx_valid), .o_tx_type(tx_type), .o_tx_cic(tx_cic),
    .o_tx_range(tx_range), .o_tx_status(tx_status), .i_call_valid(call_valid),
    .i_call_op(call_op), .i_call_cic(call_cic), .o_seize_ok(), .o_retry(retry),
    .o_release(rel), .o_hw_release(hwr), .o_setup_accept(acc), .o_setup_discard(dis),
    .o_maint_note(note), .o_busy(bsy));
  cbm_peer peer (.i_clk(clk), .i_rst_b(rst_b), .i_tx_valid(tx_valid), .i_tx_type(tx_type),
    .i_tx_cic(tx_cic), .i_tx_range(tx_range), .i_tx_status(tx_status), .i_drop(drop),
    .o_valid(pv), .o_type(pt), .o_cic(pc), .o_range(pr), .o_status(ps));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  function automatic cbm_msg_type ack_of(input cbm_msg_type m);
    return cbm_msg_type'(m + 4'h2);
  endfunction : ack_of
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {addr, wdata, wr_en} <= {a, v, 1'b1};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    {addr, rd_en} <= {a, 1'b1};
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask : rd
  // One received message, then sample the answer slot
  task automatic msg(input cbm_msg_type m, input logic [4:0] k, input logic [7:0] r,
                     input logic [31:0] s);
    repeat (2) @(posedge clk);
    {bv, bc, br, bs} <= {1'b1, k, r, s};
    bt <= m;
    @(posedge clk);
    {bv, bs} <= {1'b0, ~s};
    #1;
  endtask : msg
  task automatic wait_tx;
    do @(posedge clk); while (tx_valid !== 1'b1);
  endtask : wait_tx
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    if (++cyc == 5000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    {rst_b, wr_en, rd_en, bv, btst, call_valid, addr, wdata, bc, br, bs, drop, call_cic} = '0;
    bt = MSG_NONE;
    call_op = OP_NOP;
    {seed, rem_exp} = {32'h651a_0016, 32'h0000_00F0};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_ALLOC, d);
    check("alloc", d, ALLOC_RST);
    rd(8'hFC, d);
    check("unmapped", d, 32'h0000_0000);
    @(posedge clk);
    {call_valid, call_cic} <= {1'b1, 5'd5};
    call_op <= OP_SETUP_SENT;
    @(posedge clk);
    call_valid <= 1'b0;
    msg(MSG_MGRP_BLOCK, 5'd4, 8'd3, 32'hF);
    check("grp ack", {note, tx_type, tx_status}, {1'b1, ack_of(MSG_MGRP_BLOCK), 32'hF});
    #8 check("retry", {retry ^ 32'h20, rel}, 64'h20);
    msg(MSG_HGRP_UNBLOCK, 5'd4, 8'd3, 32'hF);
    msg(MSG_MGRP_BLOCK, 5'd4, 8'h20, 32'h1);
    check("oversize", tx_valid, 32'h0);
    $display("end group");
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      c = (seed[4:0] == 5'h0) ? 5'h1 : seed[4:0];
      t = seed[8] ? MSG_BLOCK : MSG_UNBLOCK;
      rem_exp[c] = seed[8];
      msg(t, c, 8'h0, 32'h0);
      check("single ack", {tx_cic, tx_type}, {c, ack_of(t)});
    end
    msg(MSG_SETUP, 5'd2, 8'h0, 32'h0);
    check("accept", acc, 32'h1);
    rem_exp[2] = 1'b0;
    rd(ADDR_REM_MB, d);
    check("remote maint", d, rem_exp);
    $display("end singles");
    wr(ADDR_REQ_SEL, 32'h3);
    drop <= 32'h2;
    wr(ADDR_REQ_CMD, 32'h0001_0805);
    wait_tx();
    drop <= 32'h0;
    wait_tx();
    check("repeat", {bsy, tx_type, tx_status}, {1'b1, MSG_MGRP_BLOCK, 32'h2});
    repeat (4) @(posedge clk);
    rd(ADDR_LOC_MB, d);
    check("local maint", d, 32'h300);
    msg(MSG_SETUP, 5'd8, 8'h0, 32'h0);
    check("discard", dis, 32'h1);
    btst <= 1'b1;
    msg(MSG_SETUP, 5'd9, 8'h0, 32'h0);
    check("test call", acc, 32'h1);
    msg(MSG_HGRP_BLOCK, 5'd2, 8'h0, 32'h1);
    check("hw release", hwr, 32'h4);
    rd(ADDR_SEIZE, d);
    check("seize", d, ALLOC_RST & ~rem_exp & 32'hFFFF_FCFB);
    $display("end local");
    conclude();
  end
endmodule : tb

// ### verilog/cbm_pkg.sv
// Constants and types for the circuit blocking manager
// Overview of operation
// - Block during early outgoing set-up makes the call retry on another circuit.
// - Early block: send acknowledgement first, then release the attempt, bar the circuit.
// - Block after backward message or incoming set-up only bars later seizure.
// - Acknowledgements never wait for a call on the circuit to finish.
// - Set-up after our block: accept test calls if possible, else resend block.
// - Maintenance and hardware group variants exist, each with its own acknowledgement.
// - Group acknowledgement valid only if code, type and range match our request.
// - Status bits of unallocated codes are zero; set bits name controlled circuits.
// - Single and maintenance group blocking share one maintenance state.
// - Hardware group unblock leaves the maintenance state untouched.
// - Hardware blocking busy circuits releases them and leaves them idle blocked.
// - Only hardware group unblock or a non-test set-up clears the hardware block state.
// - Redundant block or unblock requests are still acknowledged.
// - Codes that cannot be acknowledged keep their acknowledgement bit clear.
// - Missing acknowledgement bits make the group request repeat for those circuits.
// - Unrequested acknowledgement bits disagreeing with local state trigger corrective request.
// - Unexpected group acknowledgement: discard if consistent, else send opposite request.
// - Group messages naming more than 32 circuits are discarded.
// - Unexpected single acknowledgement: discard if consistent, else send opposite request.
// - Non-test set-up clears remote blocks unless locally blocked, then discarded.
// - Any blocking raises a maintenance notification.
// - Remote block bars outgoing non-test calls; incoming test calls still allowed.
// - Circuit returns to service on sending or on receiving the unblock acknowledgement.
package cbm_pkg;

  localparam int unsigned NCIRC     = 32;
  localparam int unsigned CIC_W     = 5;
  localparam int unsigned RANGE_W   = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam logic [7:0]  RANGE_MAX = 8'h1F;
  localparam logic [31:0] NC_ONE    = 32'h0000_0001;

  // Register offsets
  localparam logic [7:0] ADDR_ALLOC   = 8'h00;
  localparam logic [7:0] ADDR_REQ_SEL = 8'h04;
  localparam logic [7:0] ADDR_REQ_CMD = 8'h08;
  localparam logic [7:0] ADDR_PEND    = 8'h0C;
  localparam logic [7:0] ADDR_LOC_MB  = 8'h10;
  localparam logic [7:0] ADDR_LOC_HB  = 8'h14;
  localparam logic [7:0] ADDR_REM_MB  = 8'h18;
  localparam logic [7:0] ADDR_REM_HB  = 8'h1C;
  localparam logic [7:0] ADDR_SEIZE   = 8'h20;

  // Command register fields and reset values
  localparam int unsigned CMD_TYPE_LSB  = 0;
  localparam int unsigned CMD_CIC_LSB   = 8;
  localparam int unsigned CMD_RANGE_LSB = 16;
  localparam int unsigned CMD_PEND_BIT  = 31;
  localparam int unsigned CMD_SEND_BIT  = 30;
  localparam logic [31:0] ALLOC_RST     = 32'hFFFF_FFFE;

  typedef enum logic [3:0] {
    MSG_NONE             = 4'b0000,
    MSG_BLOCK            = 4'b0001,
    MSG_UNBLOCK          = 4'b0010,
    MSG_BLOCK_ACK        = 4'b0011,
    MSG_UNBLOCK_ACK      = 4'b0100,
    MSG_MGRP_BLOCK       = 4'b0101,
    MSG_MGRP_UNBLOCK     = 4'b0110,
    MSG_MGRP_BLOCK_ACK   = 4'b0111,
    MSG_MGRP_UNBLOCK_ACK = 4'b1000,
    MSG_HGRP_BLOCK       = 4'b1001,
    MSG_HGRP_UNBLOCK     = 4'b1010,
    MSG_HGRP_BLOCK_ACK   = 4'b1011,
    MSG_HGRP_UNBLOCK_ACK = 4'b1100,
    MSG_SETUP            = 4'b1101
  } cbm_msg_type;

  typedef enum logic [1:0] {
    CALL_IDLE     = 2'b00,
    CALL_OUT_WAIT = 2'b01,
    CALL_OUT_ANS  = 2'b10,
    CALL_IN_BUSY  = 2'b11
  } cbm_call_type;

  typedef enum logic [1:0] {
    OP_SETUP_SENT = 2'b00,
    OP_BACKWARD   = 2'b01,
    OP_RELEASED   = 2'b10,
    OP_NOP        = 2'b11
  } cbm_op_type;

endpackage : cbm_pkg

// ### verilog/cbm_top.sv
// Circuit blocking manager: block state per circuit, request tracking and replies
module cbm_top (
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_b,
  input  wire logic [cbm_pkg::ADDR_W-1:0]     i_addr,
  input  wire logic [31:0]                    i_wr_data,
  input  wire logic                           i_wr_en,
  input  wire logic                           i_rd_en,
  output logic      [31:0]                    o_rd_data,
  input  wire logic                           i_rx_valid,
  input  wire cbm_pkg::cbm_msg_type           i_rx_type,
  input  wire logic [cbm_pkg::CIC_W-1:0]      i_rx_cic,
  input  wire logic [cbm_pkg::RANGE_W-1:0]    i_rx_range,
  input  wire logic [cbm_pkg::NCIRC-1:0]      i_rx_status,
  input  wire logic                           i_rx_test,
  output logic                                o_tx_valid,
  output cbm_pkg::cbm_msg_type                o_tx_type,
  output logic      [cbm_pkg::CIC_W-1:0]      o_tx_cic,
  output logic      [cbm_pkg::RANGE_W-1:0]    o_tx_range,
  output logic      [cbm_pkg::NCIRC-1:0]      o_tx_status,
  input  wire logic                           i_call_valid,
  input  wire cbm_pkg::cbm_op_type            i_call_op,
  input  wire logic [cbm_pkg::CIC_W-1:0]      i_call_cic,
  output logic      [cbm_pkg::NCIRC-1:0]      o_seize_ok,
  output logic      [cbm_pkg::NCIRC-1:0]      o_retry,
  output logic      [cbm_pkg::NCIRC-1:0]      o_release,
  output logic      [cbm_pkg::NCIRC-1:0]      o_hw_release,
  output logic                                o_setup_accept,
  output logic                                o_setup_discard,
  output logic                                o_maint_note,
  output logic                                o_busy
);
  import cbm_pkg::*;

  // Circuit window covered by a code and a range
  function automatic logic [NCIRC-1:0] win_mask(input logic [CIC_W-1:0]   cic,
                                                input logic [RANGE_W-1:0] rng);
    logic [NCIRC-1:0] m;
    m = '0;
    for (int j = 0; j < NCIRC; j++) begin
      m[j] = (j >= int'(cic)) && (j <= int'(cic) + int'(rng));
    end
    return m;
  endfunction : win_mask

  // Acknowledgement type expected for a request type
  function automatic cbm_msg_type ack_of(input cbm_msg_type t);
    case (t)
      MSG_BLOCK:        ack_of = MSG_BLOCK_ACK;
      MSG_UNBLOCK:      ack_of = MSG_UNBLOCK_ACK;
      MSG_MGRP_BLOCK:   ack_of = MSG_MGRP_BLOCK_ACK;
      MSG_MGRP_UNBLOCK: ack_of = MSG_MGRP_UNBLOCK_ACK;
      MSG_HGRP_BLOCK:   ack_of = MSG_HGRP_BLOCK_ACK;
      MSG_HGRP_UNBLOCK: ack_of = MSG_HGRP_UNBLOCK_ACK;
      default:          ack_of = MSG_NONE;
    endcase
  endfunction : ack_of

  // True for request types that carry a range and status field
  function automatic logic is_group(input cbm_msg_type t);
    return (t == MSG_MGRP_BLOCK) || (t == MSG_MGRP_UNBLOCK) ||
           (t == MSG_HGRP_BLOCK) || (t == MSG_HGRP_UNBLOCK);
  endfunction : is_group

  // Per-circuit state
  logic [NCIRC-1:0]  alloc_q;
  logic [NCIRC-1:0]  req_sel_q;
  logic [NCIRC-1:0]  lmb_q;
  logic [NCIRC-1:0]  lhb_q;
  logic [NCIRC-1:0]  rmb_q;
  logic [NCIRC-1:0]  rhb_q;
  cbm_call_type      call_q [NCIRC];
  logic [NCIRC-1:0]  out_wait;
  logic [NCIRC-1:0]  busy;

  // Outstanding local request
  logic              pend_q;
  logic              send_q;
  cbm_msg_type       pend_type_q;
  logic [CIC_W-1:0]  pend_cic_q;
  logic [RANGE_W-1:0] pend_range_q;
  logic [NCIRC-1:0]  pend_sel_q;
  logic [NCIRC-1:0]  early_q;

  // Command decode
  cbm_msg_type       cmd_type;
  logic [CIC_W-1:0]  cmd_cic;
  logic [RANGE_W-1:0] cmd_range;
  logic              cmd_ok;

  // Combinational results of one received message
  logic [NCIRC-1:0]  cb;
  logic [NCIRC-1:0]  rx_abs;
  logic [NCIRC-1:0]  loc_sel;
  logic [NCIRC-1:0]  fix;
  logic [NCIRC-1:0]  pend_blk;
  logic              rx_ok;
  logic              match;
  logic              hw;
  logic              blk;
  logic [NCIRC-1:0]  set_rmb, clr_rmb, set_rhb, clr_rhb;
  logic [NCIRC-1:0]  set_lmb, clr_lmb, set_lhb, clr_lhb;
  logic [NCIRC-1:0]  early_d;
  logic [NCIRC-1:0]  hwrel_d;
  logic [NCIRC-1:0]  go_in;
  logic [NCIRC-1:0]  resend_sel;
  logic              pend_clr;
  logic              pend_resend;
  logic              issue;
  logic              accept_d;
  logic              discard_d;
  logic              tx_valid_d;
  cbm_msg_type       tx_type_d;
  logic [CIC_W-1:0]  tx_cic_d;
  logic [RANGE_W-1:0] tx_range_d;
  logic [NCIRC-1:0]  tx_status_d;

  // Call state masks
  for (genvar g = 0; g < NCIRC; g++) begin : g_call
    assign out_wait[g] = (call_q[g] == CALL_OUT_WAIT);
    assign busy[g]     = (call_q[g] != CALL_IDLE);
  end

  // Software request decode; a new request is ignored while the previous one is pending
  assign cmd_type  = cbm_msg_type'(i_wr_data[CMD_TYPE_LSB +: 4]);
  assign cmd_cic   = i_wr_data[CMD_CIC_LSB +: CIC_W];
  assign cmd_range = i_wr_data[CMD_RANGE_LSB +: RANGE_W];
  assign cmd_ok    = i_wr_en && (i_addr == ADDR_REQ_CMD) && !pend_q &&
                     (ack_of(cmd_type) != MSG_NONE) &&
                     (cmd_range <= RANGE_MAX);
  assign pend_blk  = (pend_q && (pend_type_q == MSG_BLOCK || pend_type_q == MSG_MGRP_BLOCK ||
                      pend_type_q == MSG_HGRP_BLOCK)) ? pend_sel_q : '0;

  // Handling of one received message and of the local request issue
  always_comb begin
    cb          = NC_ONE << i_rx_cic;
    rx_abs      = (i_rx_status << i_rx_cic) & win_mask(i_rx_cic, i_rx_range) &
                  alloc_q;
    rx_ok       = i_rx_valid && (i_rx_range <= RANGE_MAX);
    match       = pend_q && (i_rx_type == ack_of(pend_type_q)) &&
                  (i_rx_cic == pend_cic_q) &&
                  (!is_group(pend_type_q) || i_rx_range == pend_range_q);
    hw          = (i_rx_type == MSG_HGRP_BLOCK_ACK) || (i_rx_type == MSG_HGRP_UNBLOCK_ACK);
    blk         = (i_rx_type == MSG_MGRP_BLOCK_ACK) || (i_rx_type == MSG_HGRP_BLOCK_ACK);
    loc_sel     = hw ? lhb_q : lmb_q;
    fix         = '0;
    set_rmb     = '0;
    clr_rmb     = '0;
    set_rhb     = '0;
    clr_rhb     = '0;
    set_lmb     = '0;
    clr_lmb     = '0;
    set_lhb     = '0;
    clr_lhb     = '0;
    early_d     = '0;
    hwrel_d     = '0;
    go_in       = '0;
    resend_sel  = '0;
    pend_clr    = 1'b0;
    pend_resend = 1'b0;
    issue       = 1'b0;
    accept_d    = 1'b0;
    discard_d   = 1'b0;
    tx_valid_d  = 1'b0;
    tx_type_d   = MSG_NONE;
    tx_cic_d    = i_rx_cic;
    tx_range_d  = i_rx_range;
    tx_status_d = rx_abs >> i_rx_cic;
    if (rx_ok) begin
      case (i_rx_type)
        MSG_BLOCK: begin
          set_rmb    = cb;
          early_d    = cb & out_wait;
          tx_valid_d = 1'b1;
          tx_type_d  = MSG_BLOCK_ACK;
          tx_range_d = '0;
          tx_status_d = '0;
        end
        MSG_UNBLOCK: begin
          clr_rmb    = cb;
          tx_valid_d = 1'b1;
          tx_type_d  = MSG_UNBLOCK_ACK;
          tx_range_d = '0;
          tx_status_d = '0;
        end
        MSG_MGRP_BLOCK: begin
          set_rmb    = rx_abs;
          early_d    = rx_abs & out_wait;
          tx_valid_d = 1'b1;
          tx_type_d  = MSG_MGRP_BLOCK_ACK;
        end
        MSG_MGRP_UNBLOCK: begin
          clr_rmb    = rx_abs;
          tx_valid_d = 1'b1;
          tx_type_d  = MSG_MGRP_UNBLOCK_ACK;
        end
        MSG_HGRP_BLOCK: begin
          set_rhb    = rx_abs;
          hwrel_d    = rx_abs & busy;
          tx_valid_d = 1'b1;
          tx_type_d  = MSG_HGRP_BLOCK_ACK;
        end
        MSG_HGRP_UNBLOCK: begin
          clr_rhb    = rx_abs;
          tx_valid_d = 1'b1;
          tx_type_d  = MSG_HGRP_UNBLOCK_ACK;
        end
        MSG_BLOCK_ACK: begin
          tx_range_d  = '0;
          tx_status_d = '0;
          if (match) begin
            set_lmb  = pend_sel_q;
            pend_clr = 1'b1;
          end else if ((lmb_q & cb) == '0) begin
            tx_valid_d = 1'b1;
            tx_type_d  = MSG_UNBLOCK;
          end
        end
        MSG_UNBLOCK_ACK: begin
          tx_range_d  = '0;
          tx_status_d = '0;
          if (match) begin
            clr_lmb  = pend_sel_q;
            pend_clr = 1'b1;
          end else if ((lmb_q & cb) != '0) begin
            tx_valid_d = 1'b1;
            tx_type_d  = MSG_BLOCK;
          end
        end
        MSG_MGRP_BLOCK_ACK, MSG_MGRP_UNBLOCK_ACK,
        MSG_HGRP_BLOCK_ACK, MSG_HGRP_UNBLOCK_ACK: begin
          if (match) begin
            if (blk && hw) set_lhb = rx_abs & pend_sel_q;
            if (blk && !hw) set_lmb = rx_abs & pend_sel_q;
            if (!blk && hw) clr_lhb = rx_abs & pend_sel_q;
            if (!blk && !hw) clr_lmb = rx_abs & pend_sel_q;
            resend_sel = pend_sel_q & ~rx_abs;
            pend_resend = (resend_sel != '0);
            pend_clr    = (resend_sel == '0);
          end
          // Bits that disagree with local state get the opposite request
          fix = rx_abs & ~(match ? pend_sel_q : '0) &
                (blk ? ~loc_sel : loc_sel);
          if (fix != '0) begin
            tx_valid_d  = 1'b1;
            tx_status_d = fix >> i_rx_cic;
            if (hw) tx_type_d = blk ? MSG_HGRP_UNBLOCK : MSG_HGRP_BLOCK;
            else    tx_type_d = blk ? MSG_MGRP_UNBLOCK : MSG_MGRP_BLOCK;
          end
        end
        MSG_SETUP: begin
          tx_range_d  = '0;
          tx_status_d = NC_ONE;
          if (((lmb_q | lhb_q | pend_blk) & cb) != '0) begin
            if (i_rx_test && ((busy & cb) == '0)) begin
              accept_d = 1'b1;
              go_in    = cb;
            end else begin
              discard_d  = 1'b1;
              tx_valid_d = 1'b1;
              tx_type_d  = ((lhb_q & cb) != '0) ? MSG_HGRP_BLOCK : MSG_BLOCK;
            end
          end else begin
            if (!i_rx_test) begin
              clr_rmb = cb;
              clr_rhb = cb;
            end
            accept_d = 1'b1;
            go_in    = cb;
          end
          if (tx_type_d == MSG_BLOCK) tx_status_d = '0;
        end
        default: begin
          tx_valid_d = 1'b0;
        end
      endcase
    end
    // Local request goes out in a cycle with no received message
    if (!i_rx_valid && pend_q && send_q) begin
      issue       = 1'b1;
      tx_valid_d  = 1'b1;
      tx_type_d   = pend_type_q;
      tx_cic_d    = pend_cic_q;
      tx_range_d  = is_group(pend_type_q) ? pend_range_q : '0;
      tx_status_d = is_group(pend_type_q) ? (pend_sel_q >> pend_cic_q) : '0;
      if (pend_type_q == MSG_HGRP_BLOCK) hwrel_d = pend_sel_q & busy;
    end
  end

  // Software visible configuration
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      alloc_q   <= ALLOC_RST;
      req_sel_q <= '0;
    end else if (i_wr_en) begin
      if (i_addr == ADDR_ALLOC) alloc_q <= i_wr_data;
      else if (i_addr == ADDR_REQ_SEL) req_sel_q <= i_wr_data;
    end
  end

  // Outstanding request record and its per-circuit pending flags
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_q       <= 1'b0;
      send_q       <= 1'b0;
      pend_type_q  <= MSG_NONE;
      pend_cic_q   <= '0;
      pend_range_q <= '0;
      pend_sel_q   <= '0;
    end else if (cmd_ok) begin
      pend_q       <= 1'b1;
      send_q       <= 1'b1;
      pend_type_q  <= cmd_type;
      pend_cic_q   <= cmd_cic;
      pend_range_q <= is_group(cmd_type) ? cmd_range : '0;
      pend_sel_q   <= is_group(cmd_type) ?
                      ((req_sel_q << cmd_cic) & win_mask(cmd_cic, cmd_range) & alloc_q) :
                      (NC_ONE << cmd_cic);
    end else begin
      if (pend_clr) pend_q <= 1'b0;
      if (pend_resend) begin
        pend_sel_q <= resend_sel;
        send_q     <= 1'b1;
      end else if (issue) begin
        send_q <= 1'b0;
      end
    end
  end

  // Maintenance block flags, shared by single and group procedures
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lmb_q <= '0;
      rmb_q <= '0;
    end else begin
      lmb_q <= (lmb_q & ~clr_lmb) | set_lmb;
      rmb_q <= (rmb_q & ~clr_rmb) | set_rmb;
    end
  end

  // Hardware block flags
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lhb_q <= '0;
      rhb_q <= '0;
    end else begin
      lhb_q <= (lhb_q & ~clr_lhb) | set_lhb;
      rhb_q <= (rhb_q & ~clr_rhb) | set_rhb;
    end
  end

  // Call state per circuit; block handling overrides call control events
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < NCIRC; k++) begin
        call_q[k] <= CALL_IDLE;
      end
    end else begin
      for (int k = 0; k < NCIRC; k++) begin
        if (early_d[k] || hwrel_d[k]) begin
          call_q[k] <= CALL_IDLE;
        end else if (go_in[k]) begin
          call_q[k] <= CALL_IN_BUSY;
        end else if (i_call_valid && (i_call_cic == CIC_W'(k))) begin
          case (i_call_op)
            OP_SETUP_SENT: call_q[k] <= CALL_OUT_WAIT;
            OP_BACKWARD: begin
              if (call_q[k] == CALL_OUT_WAIT) call_q[k] <= CALL_OUT_ANS;
            end
            OP_RELEASED: call_q[k] <= CALL_IDLE;
            default: call_q[k] <= call_q[k];
          endcase
        end
      end
    end
  end

  // Outgoing message register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tx_valid  <= 1'b0;
      o_tx_type   <= MSG_NONE;
      o_tx_cic    <= '0;
      o_tx_range  <= '0;
      o_tx_status <= '0;
    end else begin
      o_tx_valid  <= tx_valid_d;
      o_tx_type   <= tx_type_d;
      o_tx_cic    <= tx_cic_d;
      o_tx_range  <= tx_range_d;
      o_tx_status <= tx_status_d;
    end
  end

  // Call side pulses: early release follows the acknowledgement by one cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      early_q         <= '0;
      o_retry         <= '0;
      o_release       <= '0;
      o_hw_release    <= '0;
      o_setup_accept  <= 1'b0;
      o_setup_discard <= 1'b0;
      o_maint_note    <= 1'b0;
    end else begin
      early_q         <= early_d;
      o_retry         <= early_q;
      o_release       <= early_q;
      o_hw_release    <= hwrel_d;
      o_setup_accept  <= accept_d;
      o_setup_discard <= discard_d;
      o_maint_note    <= ((set_rmb | set_rhb | set_lmb | set_lhb) != '0);
    end
  end

  // Seizure permission and pending indication
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_seize_ok <= '0;
      o_busy     <= 1'b0;
    end else begin
      o_seize_ok <= alloc_q & ~busy & ~(lmb_q | lhb_q | rmb_q | rhb_q) &
                    ~(pend_q ? pend_sel_q : '0);
      o_busy     <= pend_q;
    end
  end

  // Register read port, data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= '0;
    end else if (!i_rd_en) begin
      o_rd_data <= '0;
    end else if (i_addr == ADDR_ALLOC) begin
      o_rd_data <= alloc_q;
    end else if (i_addr == ADDR_REQ_SEL) begin
      o_rd_data <= req_sel_q;
    end else if (i_addr == ADDR_REQ_CMD) begin
      o_rd_data <= {pend_q, send_q, 6'h00, pend_range_q, 3'h0, pend_cic_q,
                    4'h0, pend_type_q};
    end else if (i_addr == ADDR_PEND) begin
      o_rd_data <= pend_q ? pend_sel_q : '0;
    end else if (i_addr == ADDR_LOC_MB) begin
      o_rd_data <= lmb_q;
    end else if (i_addr == ADDR_LOC_HB) begin
      o_rd_data <= lhb_q;
    end else if (i_addr == ADDR_REM_MB) begin
      o_rd_data <= rmb_q;
    end else if (i_addr == ADDR_REM_HB) begin
      o_rd_data <= rhb_q;
    end else if (i_addr == ADDR_SEIZE) begin
      o_rd_data <= o_seize_ok;
    end else begin
      o_rd_data <= '0;
    end
  end

endmodule : cbm_top
